/* File: rtl/afc_pkg.sv */
// shared constants for the api request frame codec ends
`default_nettype none
package afc_pkg;
  localparam logic [7:0] SOF = 8'h7E;
  localparam logic [7:0] TYPE_EXPL = 8'h11;
  localparam logic [7:0] TYPE_REMOTE = 8'h17;
  localparam logic [7:0] TYPE_REMOTE_RSP = 8'h97;
  localparam logic [7:0] TYPE_TX_STATUS = 8'h8B;
  localparam logic [7:0] TYPE_ROUTE_INFO = 8'h8D;
  // absolute byte offsets within a frame
  localparam logic [15:0] OFS_LEN_HI = 16'h0001;
  localparam logic [15:0] OFS_LEN_LO = 16'h0002;
  localparam logic [15:0] OFS_TYPE = 16'h0003;
  localparam logic [15:0] OFS_ID = 16'h0004;
  localparam logic [15:0] OFS_RSV = 16'h000D;
  localparam logic [15:0] OFS_ROPT = 16'h000F;
  localparam logic [15:0] OFS_CMD = 16'h0010;
  localparam logic [15:0] OFS_PARAM = 16'h0012;
  localparam logic [15:0] OFS_CLUSTER = 16'h0011;
  localparam logic [15:0] OFS_TXOPT = 16'h0016;
  localparam logic [15:0] OFS_PAYLOAD = 16'h0017;
  localparam logic [15:0] HDR_BYTES = 16'h0003;
  localparam logic [15:0] REMOTE_QUERY_LEN = 16'h000F;
  localparam logic [15:0] EXPL_FIXED_LEN = 16'h0014;
  // transmit-options byte
  localparam logic [7:0] TXO_FAILURE_NOTICE_OPTION = 8'h04;
  localparam logic [7:0] TXO_TRACE = 8'h08;
  localparam logic [7:0] TXO_SECURE = 8'h10;
  localparam logic [7:0] TXO_USED = 8'hDF;
  localparam logic [7:0] TXO_METHOD = 8'hC0;
  localparam logic [7:0] METHOD_INVALID = 8'h00;
  localparam logic [15:0] SECURE_SHRINK = 16'h0004;
  // remote options byte
  localparam logic [7:0] RO_APPLY = 8'h02;
  localparam logic [7:0] RO_USED = 8'h13;
  localparam logic [15:0] LOOPBACK_CLUSTER = 16'h0012;
  localparam logic [15:0] APPLY_CMD = 16'h4143;
  localparam logic [15:0] RSV_FIELD = 16'hFFFE;
  localparam logic [7:0] DATA_EP = 8'hE8;
  localparam logic [7:0] STAT_OK = 8'h00;
  localparam logic [7:0] STAT_ERR = 8'h01;
  localparam logic [7:0] CSUM_BASE = 8'hFF;
endpackage : afc_pkg
`default_nettype wire

/* File: rtl/afc_if.sv */
// byte stream carrier joining the host end and the device end
`default_nettype none
interface afc_if;
  logic [7:0] h2d_data;
  logic h2d_valid;
  logic h2d_ready;
  logic [7:0] d2h_data;
  logic d2h_valid;
  logic d2h_ready;
  modport host (output h2d_data, output h2d_valid, input h2d_ready,
                input d2h_data, input d2h_valid, output d2h_ready);
  modport dev (input h2d_data, input h2d_valid, output h2d_ready,
               output d2h_data, output d2h_valid, input d2h_ready);
endinterface : afc_if
`default_nettype wire

/* File: rtl/afc_dev_end.sv */
// device end: fifo, parser, option handling, responder
// Function
// - tx bit0 disables unicast acks; the device end only passes it on in tx_opts_o
// - tx bit1 stops route discovery; the device end only passes it on in tx_opts_o
// - failure_notice_option bit and failure send 8D
// - trace bit sends 8D frame
// - secure bit, payload limit minus four
// - host zeroes reserved tx bits
// - bits 7:6 pick delivery method
// - zero options use stored defaults
// - nonzero id gets 8B status
// - loopback cluster returns to sender
// - remote request gets matching 97
// - zero id suppresses remote response
// - fixed remote field offsets
// - no parameter means query
// - apply bit or apply command commits
// - remote reserved option bits zero
// - length counts body bytes
// - checksum is ff minus body sum
// - frame opens with delimiter
// - remote requests unicast only; neither end checks the destination
// - tx options at 22, payload 23
`default_nettype none
module afc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i, // clock
  input wire logic resetn_i, // async reset, low
  input wire logic [WIDTH-1:0] in_data_i, // write data
  input wire logic in_valid_i, // write request
  output logic in_ready_o, // room available
  output logic [WIDTH-1:0] out_data_o, // head word
  output logic out_valid_o, // head valid
  input wire logic out_ready_i // head taken
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  logic push;
  logic pop;
  assign in_ready_o = (wp_r - rp_r) != (AW+1)'(DEPTH);
  assign out_valid_o = wp_r != rp_r;
  assign out_data_o = mem[rp_r[AW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule : afc_fifo

module afc_dev_end import afc_pkg::*; #(
  parameter logic [15:0] MAX_PAYLOAD = 16'h0040,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk_i,               // clock
  input wire logic resetn_i,            // async reset, low
  afc_if.dev link, // frame byte streams
  input wire logic [7:0] dflt_tx_opts_i, // default tx options
  input wire logic [7:0] cur_value_i, // queried value
  input wire logic tx_done_i, // send finished
  input wire logic tx_ok_i, // send succeeded
  output logic tx_start_o, // pulse: start send
  output logic [7:0] tx_opts_o, // effective tx options
  output logic tx_loopback_o, // loopback send
  output logic [15:0] tx_len_o, // payload length
  output logic loop_rx_o, // pulse: loopback returned
  output logic [15:0] param_cmd_o, // command
  output logic [7:0] param_val_o, // committed value
  output logic param_wr_o, // pulse: commit
  output logic param_pend_o // change pending
);
  typedef enum logic [1:0] {
    ST_RX = 2'b00,
    ST_WAIT = 2'b01,
    ST_SEND = 2'b11,
    ST_NEXT = 2'b10
  } afc_dst_t;
  afc_dst_t st_r;
  logic [7:0] rx_d;
  logic rx_v;
  logic rx_rdy;
  logic pop;
  logic [15:0] cnt_r;
  logic [15:0] len_r;
  logic [7:0] sum_r;
  logic [7:0] typ_r;
  logic [7:0] id_r;
  logic [7:0] opt_r;
  logic [15:0] cmd_r;
  logic [7:0] par_r;
  logic [15:0] clu_r;
  logic frm_r;
  logic [7:0] rb_r [6];
  logic [2:0] rlen_r;
  logic route_r;
  logic loop_r;
  logic [15:0] pcmd_r;
  logic [7:0] pval_r;
  logic [3:0] oi_r;
  logic done_r;
  logic [7:0] txd_r;
  logic txv_r;
  logic [7:0] eff;
  logic [15:0] lim;
  logic [15:0] plen;

  afc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .in_data_i(link.h2d_data),
    .in_valid_i(link.h2d_valid),
    .in_ready_o(link.h2d_ready),
    .out_data_o(rx_d),
    .out_valid_o(rx_v),
    .out_ready_i(rx_rdy)
  );
  assign rx_rdy = (st_r == ST_RX) && !frm_r;
  assign pop = rx_v && rx_rdy;
  assign link.d2h_data = txd_r;
  assign link.d2h_valid = txv_r;

  function automatic logic [7:0] csum(input logic [7:0] b [6], input logic [2:0] n);
    logic [7:0] s;
    s = '0;
    for (int i = 0; i < 6; i++) begin
      if (3'(i) < n) begin
        s = s + b[i];
      end
    end
    return CSUM_BASE - s;
  endfunction : csum

  // parser
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r <= '0;
      len_r <= '0;
      sum_r <= '0;
      typ_r <= '0;
      id_r <= '0;
      opt_r <= '0;
      cmd_r <= '0;
      par_r <= '0;
      clu_r <= '0;
      frm_r <= 1'b0;
    end else begin
      frm_r <= 1'b0;
      if (pop) begin
        cnt_r <= cnt_r + 16'h0001;
        if (cnt_r == '0) begin
          sum_r <= '0;
          if (rx_d != SOF) begin
            cnt_r <= '0;
          end
        end else if (cnt_r == OFS_LEN_HI) begin
          len_r[15:8] <= rx_d;
        end else if (cnt_r == OFS_LEN_LO) begin
          len_r[7:0] <= rx_d;
        end else if (cnt_r < len_r + HDR_BYTES) begin
          sum_r <= sum_r + rx_d;
          if (cnt_r == OFS_TYPE) typ_r <= rx_d;
          if (cnt_r == OFS_ID) id_r <= rx_d;
          if (cnt_r == OFS_ROPT) opt_r <= rx_d;
          if (cnt_r == OFS_CMD) cmd_r[15:8] <= rx_d;
          if (cnt_r == OFS_CMD + 16'h0001) cmd_r[7:0] <= rx_d;
          if (cnt_r == OFS_PARAM) par_r <= rx_d;
          if (cnt_r == OFS_CLUSTER) clu_r[15:8] <= rx_d;
          if (cnt_r == OFS_CLUSTER + 16'h0001) clu_r[7:0] <= rx_d;
          if (cnt_r == OFS_TXOPT) opt_r <= rx_d;
        end else begin
          cnt_r <= '0;
          frm_r <= (sum_r + rx_d) == CSUM_BASE;
        end
      end
    end
  end

  assign eff = (opt_r == '0) ? dflt_tx_opts_i : opt_r;
  assign plen = len_r - EXPL_FIXED_LEN;
  assign lim = (eff & TXO_SECURE) != '0 ? MAX_PAYLOAD - SECURE_SHRINK : MAX_PAYLOAD;

  // command execution and response choice
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= ST_RX;
      for (int i = 0; i < 6; i++) rb_r[i] <= '0;
      rlen_r <= '0;
      route_r <= 1'b0;
      loop_r <= 1'b0;
      pcmd_r <= '0;
      pval_r <= '0;
      tx_start_o <= 1'b0;
      tx_opts_o <= '0;
      tx_loopback_o <= 1'b0;
      tx_len_o <= '0;
      loop_rx_o <= 1'b0;
      param_cmd_o <= '0;
      param_val_o <= '0;
      param_wr_o <= 1'b0;
      param_pend_o <= 1'b0;
    end else begin
      tx_start_o <= 1'b0;
      loop_rx_o <= 1'b0;
      param_wr_o <= 1'b0;
      case (st_r)
        ST_RX: begin
          if (frm_r && typ_r == TYPE_REMOTE) begin
            rb_r[0] <= TYPE_REMOTE_RSP;
            rb_r[1] <= id_r;
            rb_r[2] <= cmd_r[15:8];
            rb_r[3] <= cmd_r[7:0];
            rb_r[4] <= STAT_OK;
            rb_r[5] <= cur_value_i;
            rlen_r <= 3'd5;
            param_cmd_o <= cmd_r;
            if (cmd_r == APPLY_CMD) begin
              param_wr_o <= param_pend_o;
              param_cmd_o <= pcmd_r;
              param_val_o <= pval_r;
              param_pend_o <= 1'b0;
            end else if (len_r == REMOTE_QUERY_LEN) begin
              rlen_r <= 3'd6;
            end else if ((opt_r & RO_APPLY) != '0) begin
              param_wr_o <= 1'b1;
              param_val_o <= par_r;
              param_pend_o <= 1'b0;
            end else begin
              pcmd_r <= cmd_r;
              pval_r <= par_r;
              param_pend_o <= 1'b1;
            end
            if ((opt_r & ~RO_USED) != '0) begin
              rb_r[4] <= STAT_ERR;
            end
            if (id_r != '0) begin
              st_r <= ST_SEND;
            end
          end else if (frm_r && typ_r == TYPE_EXPL) begin
            rb_r[0] <= TYPE_TX_STATUS;
            rb_r[1] <= id_r;
            rb_r[2] <= STAT_ERR;
            rlen_r <= 3'd3;
            route_r <= 1'b0;
            loop_r <= clu_r == LOOPBACK_CLUSTER;
            if ((eff & TXO_METHOD) == METHOD_INVALID || plen > lim) begin
              st_r <= (id_r != '0) ? ST_SEND : ST_RX;
            end else begin
              tx_start_o <= 1'b1;
              tx_opts_o <= eff;
              tx_loopback_o <= clu_r == LOOPBACK_CLUSTER;
              tx_len_o <= plen;
              st_r <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (tx_done_i) begin
            rb_r[2] <= tx_ok_i ? STAT_OK : STAT_ERR;
            route_r <= ((eff & TXO_TRACE) != '0) ||
                       ((eff & TXO_FAILURE_NOTICE_OPTION) != '0 && !tx_ok_i);
            loop_rx_o <= loop_r && tx_ok_i;
            if (id_r != '0) begin
              st_r <= ST_SEND;
            end else begin
              st_r <= ST_NEXT;
            end
          end
        end
        ST_SEND: begin
          if (done_r) begin
            st_r <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          if (route_r) begin
            rb_r[0] <= TYPE_ROUTE_INFO;
            rlen_r <= 3'd3;
            route_r <= 1'b0;
            st_r <= ST_SEND;
          end else begin
            st_r <= ST_RX;
          end
        end
        default: st_r <= ST_RX;
      endcase
    end
  end

  // serializer
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      oi_r <= '0;
      done_r <= 1'b0;
      txd_r <= '0;
      txv_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (st_r == ST_SEND && !done_r && (!txv_r || link.d2h_ready)) begin
        oi_r <= oi_r + 4'd1;
        txv_r <= 1'b1;
        if (oi_r == 4'd0) begin
          txd_r <= SOF;
        end else if (oi_r == 4'd1) begin
          txd_r <= '0;
        end else if (oi_r == 4'd2) begin
          txd_r <= {5'b0, rlen_r};
        end else if (oi_r - 4'd3 < {1'b0, rlen_r}) begin
          txd_r <= rb_r[3'(oi_r - 4'd3)];
        end else if (oi_r - 4'd3 == {1'b0, rlen_r}) begin
          txd_r <= csum(rb_r, rlen_r);
        end else begin
          txv_r <= 1'b0;
          oi_r <= '0;
          done_r <= 1'b1;
        end
      end else if (txv_r && link.d2h_ready) begin
        txv_r <= 1'b0;
      end
    end
  end
endmodule : afc_dev_end
`default_nettype wire

/* File: rtl/afc_host_end.sv */
// host end: builds request frames and parses response frames
`default_nettype none
module afc_host_end import afc_pkg::*; #(
  parameter logic [15:0] PROFILE_ID = 16'h1234 // arbitrary value
) (
  input wire logic clk_i, // clock
  input wire logic resetn_i, // async reset, low
  afc_if.host link, // frame byte streams
  input wire logic req_valid_i, // request offered
  output logic req_ready_o, // request taken when high
  input wire logic req_remote_i, // 1 remote, 0 explicit
  input wire logic [7:0] req_id_i, // frame id
  input wire logic [63:0] req_dest_i, // destination
  input wire logic [7:0] req_opts_i, // options byte
  input wire logic [15:0] req_cluster_i, // cluster
  input wire logic [15:0] req_cmd_i, // command characters
  input wire logic [31:0] req_data_i, // data, msb first
  input wire logic [2:0] req_dlen_i, // data bytes, 0 to 4
  output logic rsp_valid_o, // pulse: response seen
  output logic [7:0] rsp_type_o, // response type
  output logic [7:0] rsp_id_o, // response id
  output logic [7:0] rsp_status_o, // status byte
  output logic [7:0] rsp_value_o // query value
);
  logic remote_r;
  logic [7:0] id_r;
  logic [63:0] dest_r;
  logic [7:0] opt_r;
  logic [15:0] clu_r;
  logic [15:0] cmd_r;
  logic [31:0] dat_r;
  logic [15:0] blen_r;
  logic [15:0] oi_r;
  logic [7:0] osum_r;
  logic busy_r;
  logic [7:0] txd_r;
  logic txv_r;
  logic [15:0] icnt_r;
  logic [15:0] ilen_r;
  logic [7:0] isum_r;
  logic [7:0] cap_r [6];

  assign link.h2d_data = txd_r;
  assign link.h2d_valid = txv_r;
  assign link.d2h_ready = 1'b1;

  // body byte k counts from the frame type
  function automatic logic [7:0] body(input logic [15:0] k);
    logic [15:0] d;
    logic [7:0] b;
    d = remote_r ? k - (OFS_PARAM - OFS_TYPE) : k - (OFS_PAYLOAD - OFS_TYPE);
    b = dat_r[31 - 8*d[1:0] -: 8];
    if (k == 16'd0) b = remote_r ? TYPE_REMOTE : TYPE_EXPL;
    else if (k == 16'd1) b = id_r;
    else if (k < 16'd10) b = dest_r[63 - 8*(k - 16'd2) -: 8];
    else if (k == 16'd10) b = RSV_FIELD[15:8];
    else if (k == 16'd11) b = RSV_FIELD[7:0];
    else if (remote_r) begin
      if (k == 16'd12) b = opt_r & RO_USED;
      else if (k == 16'd13) b = cmd_r[15:8];
      else if (k == 16'd14) b = cmd_r[7:0];
    end else if (k < 16'd14) b = DATA_EP;
    else if (k == 16'd14) b = clu_r[15:8];
    else if (k == 16'd15) b = clu_r[7:0];
    else if (k == 16'd16) b = PROFILE_ID[15:8];
    else if (k == 16'd17) b = PROFILE_ID[7:0];
    else if (k == 16'd18) b = '0;
    else if (k == 16'd19) b = opt_r & TXO_USED;
    return b;
  endfunction : body

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      remote_r <= 1'b0;
      id_r <= '0;
      dest_r <= '0;
      opt_r <= '0;
      clu_r <= '0;
      cmd_r <= '0;
      dat_r <= '0;
      blen_r <= '0;
      oi_r <= '0;
      osum_r <= '0;
      busy_r <= 1'b0;
      txd_r <= '0;
      txv_r <= 1'b0;
      req_ready_o <= 1'b0;
    end else begin
      req_ready_o <= !busy_r && !req_ready_o;
      if (req_valid_i && req_ready_o) begin
        remote_r <= req_remote_i;
        id_r <= req_id_i;
        dest_r <= req_dest_i;
        opt_r <= req_opts_i;
        clu_r <= req_cluster_i;
        cmd_r <= req_cmd_i;
        dat_r <= req_data_i;
        blen_r <= (req_remote_i ? REMOTE_QUERY_LEN : EXPL_FIXED_LEN) + {13'b0, req_dlen_i};
        oi_r <= '0;
        osum_r <= '0;
        busy_r <= 1'b1;
        req_ready_o <= 1'b0;
      end else if (busy_r && (!txv_r || link.h2d_ready)) begin
        oi_r <= oi_r + 16'h0001;
        txv_r <= 1'b1;
        if (oi_r == '0) begin
          txd_r <= SOF;
        end else if (oi_r == OFS_LEN_HI) begin
          txd_r <= blen_r[15:8];
        end else if (oi_r == OFS_LEN_LO) begin
          txd_r <= blen_r[7:0];
        end else if (oi_r < blen_r + HDR_BYTES) begin
          txd_r <= body(oi_r - HDR_BYTES);
          osum_r <= osum_r + body(oi_r - HDR_BYTES);
        end else if (oi_r == blen_r + HDR_BYTES) begin
          txd_r <= CSUM_BASE - osum_r;
        end else begin
          txv_r <= 1'b0;
          busy_r <= 1'b0;
        end
      end else if (!busy_r && txv_r && link.h2d_ready) begin
        txv_r <= 1'b0;
      end
    end
  end

  // response parser
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      icnt_r <= '0;
      ilen_r <= '0;
      isum_r <= '0;
      for (int i = 0; i < 6; i++) cap_r[i] <= '0;
      rsp_valid_o <= 1'b0;
      rsp_type_o <= '0;
      rsp_id_o <= '0;
      rsp_status_o <= '0;
      rsp_value_o <= '0;
    end else begin
      rsp_valid_o <= 1'b0;
      if (link.d2h_valid) begin
        icnt_r <= icnt_r + 16'h0001;
        if (icnt_r == '0) begin
          isum_r <= '0;
          if (link.d2h_data != SOF) icnt_r <= '0;
        end else if (icnt_r == OFS_LEN_HI) begin
          ilen_r[15:8] <= link.d2h_data;
        end else if (icnt_r == OFS_LEN_LO) begin
          ilen_r[7:0] <= link.d2h_data;
        end else if (icnt_r < ilen_r + HDR_BYTES) begin
          isum_r <= isum_r + link.d2h_data;
          if (icnt_r - HDR_BYTES < 16'd6) cap_r[3'(icnt_r - HDR_BYTES)] <= link.d2h_data;
        end else begin
          icnt_r <= '0;
          if ((isum_r + link.d2h_data) == CSUM_BASE) begin
            rsp_valid_o <= 1'b1;
            rsp_type_o <= cap_r[0];
            rsp_id_o <= cap_r[1];
            rsp_status_o <= (cap_r[0] == TYPE_REMOTE_RSP) ? cap_r[4] : cap_r[2];
            rsp_value_o <= cap_r[5];
          end
        end
      end
    end
  end
endmodule : afc_host_end
`default_nettype wire

/* File: test/afc_link_properties.sv */
// assertions on the two byte streams between the codec ends
`default_nettype none
module afc_link_properties import afc_pkg::*; (
  input wire logic clk_i, // clock
  input wire logic resetn_i, // async reset, low
  input wire logic [7:0] h2d_data, // host byte
  input wire logic h2d_valid, // host byte offered
  input wire logic h2d_ready, // device takes byte
  input wire logic [7:0] d2h_data, // device byte
  input wire logic d2h_valid, // device byte offered
  input wire logic d2h_ready // host takes byte
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] pos_r [2];
  logic [15:0] len_r [2];
  logic [7:0] sum_r [2];
  logic [7:0] typ_r [2];
  logic [7:0] dat [2];
  logic [1:0] hs;
  logic [1:0] last;
  assign hs = {d2h_valid && d2h_ready, h2d_valid && h2d_ready};
  assign dat[0] = h2d_data;
  assign dat[1] = d2h_data;
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      last[k] = pos_r[k] >= OFS_TYPE && pos_r[k] == len_r[k] + HDR_BYTES;
    end
  end
  // byte position, length, type and running sum of each stream
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pos_r <= '{default: '0};
      len_r <= '{default: '0};
      sum_r <= '{default: '0};
      typ_r <= '{default: '0};
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (hs[k]) begin
          pos_r[k] <= last[k] ? 16'h0000 : pos_r[k] + 16'h0001;
          sum_r[k] <= (last[k] || pos_r[k] < OFS_TYPE) ? 8'h00 : sum_r[k] + dat[k];
          if (pos_r[k] == OFS_LEN_HI) len_r[k][15:8] <= dat[k];
          if (pos_r[k] == OFS_LEN_LO) len_r[k][7:0] <= dat[k];
          if (pos_r[k] == OFS_TYPE) typ_r[k] <= dat[k];
        end
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_h_end; hs[0] && last[0]; endsequence
  sequence s_d_end; hs[1] && last[1]; endsequence
  property p_h_sof; hs[0] && pos_r[0] == 16'h0000 |-> h2d_data == SOF; endproperty
  a_h_sof: assert property (p_h_sof) else $error("host frame start wrong");
  property p_d_sof; hs[1] && pos_r[1] == 16'h0000 |-> d2h_data == SOF; endproperty
  a_d_sof: assert property (p_d_sof) else $error("device frame start wrong");
  property p_h_sum; s_h_end |-> h2d_data == CSUM_BASE - sum_r[0]; endproperty
  a_h_sum: assert property (p_h_sum) else $error("host checksum wrong");
  property p_d_sum; s_d_end |-> d2h_data == CSUM_BASE - sum_r[1]; endproperty
  a_d_sum: assert property (p_d_sum) else $error("device checksum wrong");
  property p_txo;
    hs[0] && typ_r[0] == TYPE_EXPL && pos_r[0] == OFS_TXOPT |-> !h2d_data[5];
  endproperty
  a_txo: assert property (p_txo) else $error("reserved send option set");
  property p_ropt;
    hs[0] && typ_r[0] == TYPE_REMOTE && pos_r[0] == OFS_ROPT |-> (h2d_data & 8'hEC) == 8'h00;
  endproperty
  a_ropt: assert property (p_ropt) else $error("reserved remote option set");
  property p_rsv;
    hs[0] && pos_r[0] == OFS_RSV |-> h2d_data == 8'hFF ##[1:4] (hs[0] && h2d_data == 8'hFE);
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved field wrong");
  property p_len;
    hs[0] && pos_r[0] == OFS_TYPE |->
      len_r[0] >= (h2d_data == TYPE_REMOTE ? REMOTE_QUERY_LEN : EXPL_FIXED_LEN);
  endproperty
  a_len: assert property (p_len) else $error("length too short");
endmodule : afc_link_properties
`default_nettype wire

/* File: test/api_request_frame_codec_tb.sv */
// bench for both codec ends
`default_nettype none
module api_request_frame_codec_tb import afc_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  // f: remote, loopback, send ok, commit, pending
  typedef struct packed {
    logic [4:0] f; logic [7:0] id; logic [7:0] op; logic [15:0] cm; logic [2:0] dl;
    logic [1:0] n; logic [7:0] ty; logic [7:0] st; logic [7:0] txo;
  } afc_row_t;
  localparam afc_row_t ROWS [12] = '{
    '{5'h16, 8'h27, 8'h13, 16'h4E49, 3'h1, 2'h1, 8'h97, 8'h00, 8'h00},
    '{5'h14, 8'hFA, 8'h00, 16'h5450, 3'h0, 2'h1, 8'h97, 8'h00, 8'h00},
    '{5'h15, 8'h68, 8'h00, 16'h4944, 3'h2, 2'h1, 8'h97, 8'h00, 8'h00},
    '{5'h16, 8'h05, 8'h00, 16'h4143, 3'h0, 2'h1, 8'h97, 8'h00, 8'h00},
    '{5'h16, 8'h00, 8'h02, 16'h4E49, 3'h1, 2'h0, 8'h00, 8'h00, 8'h00},
    '{5'h04, 8'h87, 8'h00, 16'h0000, 3'h1, 2'h1, 8'h8B, 8'h00, 8'hC1},
    '{5'h04, 8'h00, 8'hE8, 16'h0000, 3'h1, 2'h1, 8'h8D, 8'h00, 8'hC8},
    '{5'h00, 8'h44, 8'hC4, 16'h0000, 3'h1, 2'h2, 8'h8D, 8'h01, 8'hC4},
    '{5'h04, 8'h33, 8'h01, 16'h0000, 3'h1, 2'h1, 8'h8B, 8'h01, 8'h00},
    '{5'h0C, 8'h55, 8'h41, 16'h0000, 3'h1, 2'h1, 8'h8B, 8'h00, 8'h41},
    '{5'h04, 8'h66, 8'h90, 16'h0000, 3'h3, 2'h1, 8'h8B, 8'h01, 8'h00},
    '{5'h04, 8'h67, 8'h83, 16'h0000, 3'h3, 2'h1, 8'h8B, 8'h00, 8'h83}};
  logic clk_i, resetn_i, rv, rdy, rem, sv, txs, txl, tdone, tok, pwr, ppend, lprx;
  logic [7:0] rid, ropt, sty, sid, sst, sval, txo, pval, st_c, cv;
  logic [15:0] rcl, rcmd, n_rsp, n_st, n_wr, n_lp, acc, tlen;
  logic [2:0] rdl;
  logic [7:0] q2 [$];
  afc_row_t rw;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  afc_if l1 ();
  afc_if l2 ();
  afc_host_end i_afc_host_end (.clk_i(clk_i), .resetn_i(resetn_i), .link(l1.host),
    .req_valid_i(rv), .req_ready_o(rdy), .req_remote_i(rem), .req_id_i(rid),
    .req_dest_i(64'h0011223344556677), .req_opts_i(ropt), .req_cluster_i(rcl),
    .req_cmd_i(rcmd), .req_data_i(32'h52656D6F), .req_dlen_i(rdl), .rsp_valid_o(sv),
    .rsp_type_o(sty), .rsp_id_o(sid), .rsp_status_o(sst), .rsp_value_o(sval));
  afc_dev_end #(.MAX_PAYLOAD(16'h0006)) i_afc_dev_end (.clk_i(clk_i), .resetn_i(resetn_i),
    .link(l1.dev), .dflt_tx_opts_i(8'hC1), .cur_value_i(cv), .tx_done_i(tdone),
    .tx_ok_i(tok), .tx_start_o(txs), .tx_opts_o(txo), .tx_loopback_o(txl), .tx_len_o(tlen),
    .loop_rx_o(lprx), .param_cmd_o(), .param_val_o(pval), .param_wr_o(pwr),
    .param_pend_o(ppend));
  afc_dev_end i_afc_dev_end_b (.clk_i(clk_i), .resetn_i(resetn_i), .link(l2.dev),
    .dflt_tx_opts_i(8'hC1), .cur_value_i(cv), .tx_done_i(tdone), .tx_ok_i(tok),
    .tx_start_o(), .tx_opts_o(), .tx_loopback_o(), .tx_len_o(), .loop_rx_o(),
    .param_cmd_o(), .param_val_o(), .param_wr_o(), .param_pend_o());
  afc_link_properties i_afc_link_properties (.clk_i(clk_i), .resetn_i(resetn_i),
    .h2d_data(l1.h2d_data), .h2d_valid(l1.h2d_valid), .h2d_ready(l1.h2d_ready),
    .d2h_data(l1.d2h_data), .d2h_valid(l1.d2h_valid), .d2h_ready(l1.d2h_ready));
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  task automatic put(input logic [7:0] b);
    {l2.h2d_valid, l2.h2d_data} = {1'h1, b};
    do @(posedge clk_i); while (l2.h2d_ready !== 1'b1);
    #1;
  endtask : put
  task automatic frame2(input logic [7:0] fid, input logic bad);
    logic [7:0] body [15];
    logic [7:0] s;
    body = '{TYPE_REMOTE, fid, 8'h00, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77,
      8'hFF, 8'hFE, 8'h00, 8'h54, 8'h50};
    s = CSUM_BASE;
    put(SOF);
    put(8'h00);
    put(8'h0F);
    foreach (body[k]) begin
      put(body[k]);
      s = s - body[k];
    end
    put(s ^ {7'h00, bad});
    l2.h2d_valid = 1'h0;
  endtask : frame2
  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 8000) begin
      fail_count++;
      stop_test();
    end
  end
  always @(posedge clk_i) begin
    n_rsp = n_rsp + 16'(sv === 1'b1);
    n_st = n_st + 16'(txs === 1'b1);
    n_wr = n_wr + 16'(pwr === 1'b1);
    n_lp = n_lp + 16'(lprx === 1'b1);
    if (sv === 1'b1 && sty != TYPE_ROUTE_INFO) st_c = sst;
    if (l2.d2h_valid === 1'b1 && l2.d2h_ready === 1'b1) q2.push_back(l2.d2h_data);
  end
  // radio stand-in
  always begin
    @(posedge clk_i iff txs === 1'b1);
    repeat (3) @(posedge clk_i);
    #1 tdone = 1'h1;
    @(posedge clk_i);
    #1 tdone = 1'h0;
  end
  initial begin
    {resetn_i, rv, rem, tdone, tok, rid, ropt, rcl, rcmd, rdl, st_c} = '0;
    cv = 8'h5A;
    {l2.h2d_valid, l2.h2d_data, l2.d2h_ready} = 10'h001;
    repeat (6) @(posedge clk_i);
    chk("ready_in_reset", 16'(rdy), 16'h0000);
    #1 resetn_i = 1'h1;
    foreach (ROWS[i]) begin
      rw = ROWS[i];
      {n_rsp, n_st, n_wr, n_lp} = '0;
      {rem, rid, ropt, rcmd, rdl, tok} = {rw.f[4], rw.id, rw.op, rw.cm, rw.dl, rw.f[2]};
      rcl = rw.f[3] ? LOOPBACK_CLUSTER : 16'h0011;
      rv = 1'h1;
      do @(posedge clk_i); while (rdy !== 1'b1);
      #1 rv = 1'h0;
      repeat (250) @(posedge clk_i);
      #1;
      chk("rsp_count", n_rsp, 16'(rw.n));
      if (rw.n != 2'h0) begin
        chk("rsp_type", 16'(sty), 16'(rw.ty));
        chk("rsp_id", 16'(sid), 16'(rw.id));
        if (rw.ty != TYPE_ROUTE_INFO || rw.n == 2'h2) begin
          chk("status", 16'(st_c), 16'(rw.st));
        end
      end
      chk("starts", n_st, 16'(rw.txo != 8'h00));
      if (rw.txo != 8'h00) begin
        chk("tx_opts", 16'(txo), 16'(rw.txo));
        chk("loopback", 16'(txl), 16'(rw.f[3]));
        chk("tx_len", tlen, 16'(rw.dl));
      end
      chk("loop_rx", n_lp, 16'(rw.f[3]));
      chk("commits", n_wr, 16'(rw.f[1]));
      chk("pending", 16'(ppend), 16'(rw.f[0]));
      if (rw.f[1]) chk("set_value", 16'(pval), 16'h0052);
      if (rw.f[4] && rw.dl == 3'h0 && rw.cm != APPLY_CMD) begin
        chk("query", 16'(sval), 16'h005A);
      end
    end
    frame2(8'hB1, 1'h1);
    repeat (60) @(posedge clk_i);
    chk("bad_frame", 16'(q2.size()), 16'h0000);
    #1 l2.d2h_ready = 1'h0;
    frame2(8'hB2, 1'h0);
    repeat (5) @(posedge clk_i);
    #1 {l2.h2d_valid, l2.h2d_data} = {1'h1, SOF};
    acc = '0;
    repeat (30) begin
      @(posedge clk_i);
      acc = acc + 16'(l2.h2d_ready);
    end
    chk("fifo_fill", acc, 16'h0008);
    #1 {l2.h2d_valid, l2.d2h_ready} = 2'h1;
    repeat (40) @(posedge clk_i);
    chk("rsp_start", 16'(q2[0]), 16'(SOF));
    chk("rsp_type_b", 16'(q2[3]), 16'(TYPE_REMOTE_RSP));
    chk("rsp_id_b", 16'(q2[4]), 16'h00B2);
    stop_test();
  end
endmodule : api_request_frame_codec_tb
`default_nettype wire
